/* rtl/fifo_flags_defines.vh */
// constants for the fifo status flag and read-assist block
// assumes inclusion by bare name from the design files under rtl/
`ifndef FIFO_FLAGS_DEFINES_VH
`define FIFO_FLAGS_DEFINES_VH

// ----------------------------------------
// geometry
// ----------------------------------------
`define DEPTH 11'h400
`define HALF_DEPTH 11'h200
`define AE_OFFSET_RST 10'h07f

// ----------------------------------------
// apb register byte offsets
// ----------------------------------------
`define ADDR_AE_OFFSET 8'h00
`define ADDR_STATUS 8'h04
`define ADDR_IRQ_STATUS 8'h08
`define ADDR_IRQ_MASK 8'h0c
`define ADDR_CONFIG 8'h10

// ----------------------------------------
// interrupt status bit positions
// ----------------------------------------
`define IRQ_AE_FALL 0
`define IRQ_HF_FALL 1
`define IRQ_WR_REFUSED 2
`define IRQ_RD_REFUSED 3
`define IRQ_W 4

// ----------------------------------------
// output width codes
// ----------------------------------------
`define OW_X36 2'h0
`define OW_X18 2'h1
`define OW_X9 2'h2

// ----------------------------------------
// pin synchroniser vector
// ----------------------------------------
`define SYNC_W 51
// link clocks rest low and strobes high, so no false edge or request follows reset
`define SYNC_RST 51'h2ce0

`endif

/* rtl/pin_sync.v */
// three-stage pin synchroniser with agreement filter, one per bit
// assumes inputs are asynchronous to clk_sys; reset is synchronous
`timescale 1ns/1ps
module pin_sync #(
  parameter W = 8,
  parameter [W-1:0] RST_VAL = {W{1'b0}}
) (
  // clock and reset
  input wire clk_sys,
  input wire sys_rst,
  // raw pins and filtered levels
  input wire [W-1:0] pin_in,
  output wire [W-1:0] pin_lvl
);

  genvar i;
  generate
    for (i = 0; i < W; i = i + 1) begin : g_bit
      reg s1_r; // first stage, only read by s2_r
      reg s2_r;
      reg s3_r;
      reg lvl_r; // accepted level
      // shift chain; a new level is accepted only once stages two and three agree
      always @(posedge clk_sys) begin
        if (sys_rst) begin
          s1_r <= RST_VAL[i];
          s2_r <= RST_VAL[i];
          s3_r <= RST_VAL[i];
          lvl_r <= RST_VAL[i];
        end else begin
          s1_r <= pin_in[i];
          s2_r <= s1_r;
          s3_r <= s2_r;
          if (s2_r == s3_r) begin
            lvl_r <= s3_r;
          end
        end
      end
      assign pin_lvl[i] = lvl_r;
    end
  endgenerate

endmodule // pin_sync

/* rtl/fifo_flags.v */
// dual-clock 36-bit fifo: status flags, echo outputs, serial offset load, bus matching
// assumes write/read/serial clocks are slow pins sampled by clk_sys (40 MHz) and an apb master
//
// Function
// R1: standard mode: almost empty at count <= n
// R2: passthrough mode: almost empty at count <= n+1
// R3: async timing: assert on read, release on write
// R4: sync timing: almost empty updates on read edges
// R5: half full falls on write crossing half
// R6: half full rises on read reaching half
// R7: standard: half full after D/2+1 writes
// R8: passthrough: half full after D/2+2 writes
// R9: echoed read clock follows read clock always
// R10: echoed strobe low on real read only
// R11: serial bit loaded per sclk while enabled
// R12: output data on low 36/18/9 bits
// R13: input word is four 9-bit lanes
// R14: byte order selects which part first
// R15: flag timing select captured at full reset
// R16: narrow output needs two or four reads
// R17: either reset clears count and flags
//
// Register access over APB and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
`include "fifo_flags_defines.vh"
module fifo_flags (
  // system clock and reset
  input wire clk_sys,
  input wire sys_rst,
  // apb slave
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  output reg irq,
  // write side pins
  input wire wr_clk,
  input wire wr_en_n,
  input wire [35:0] din,
  // read side pins
  input wire rd_clk,
  input wire rd_en_n,
  input wire rd_select_n,
  output reg [35:0] out_bus,
  output reg echoed_rd_clk,
  output reg echoed_rd_strobe_n,
  // serial offset programming
  input wire sclk,
  input wire serial_in,
  input wire serial_prog_en_n,
  // resets and configuration straps
  input wire full_reset_n,
  input wire partial_reset_n,
  input wire flag_timing_sel,
  input wire byte_order_sel,
  input wire first_word_passthrough,
  input wire [1:0] out_width_sel,
  // flags
  output reg almost_empty_n,
  output reg half_full_n
);

  // ----------------------------------------
  // pin synchronisers
  // ----------------------------------------
  wire [`SYNC_W-1:0] lvl; // filtered pin levels
  wire [35:0] din_s;
  wire wr_clk_s, wr_en_s_n, rd_clk_s, rd_en_s_n, rd_sel_s_n;
  wire sclk_s, ser_s, sen_s_n, mrst_s_n, prst_s_n;
  wire fts_s, bos_s, first_word_passthrough_s;
  wire [1:0] ow_s;

  // data and strobes share one chain so their latency matches
  pin_sync #(.W(`SYNC_W), .RST_VAL(`SYNC_RST)) u_sync (
    .clk_sys(clk_sys),
    .sys_rst(sys_rst),
    .pin_in({din, wr_clk, wr_en_n, rd_clk, rd_en_n, rd_select_n, sclk, serial_in,
             serial_prog_en_n, full_reset_n, partial_reset_n, flag_timing_sel,
             byte_order_sel, first_word_passthrough, out_width_sel}),
    .pin_lvl(lvl)
  );
  assign {din_s, wr_clk_s, wr_en_s_n, rd_clk_s, rd_en_s_n, rd_sel_s_n, sclk_s, ser_s,
          sen_s_n, mrst_s_n, prst_s_n, fts_s, bos_s, first_word_passthrough_s, ow_s} = lvl;

  // ----------------------------------------
  // edge detection
  // ----------------------------------------
  reg wr_clk_p_r, rd_clk_p_r, sclk_p_r; // previous filtered levels
  wire wr_rise = wr_clk_s & ~wr_clk_p_r;
  wire rd_rise = rd_clk_s & ~rd_clk_p_r;
  wire sclk_rise = sclk_s & ~sclk_p_r;

  // remember last level of each link clock
  always @(posedge clk_sys) begin
    if (sys_rst) begin
      wr_clk_p_r <= 1'b0;
      rd_clk_p_r <= 1'b0;
      sclk_p_r <= 1'b0;
    end else begin
      wr_clk_p_r <= wr_clk_s;
      rd_clk_p_r <= rd_clk_s;
      sclk_p_r <= sclk_s;
    end
  end

  // ----------------------------------------
  // configuration captured during full reset
  // ----------------------------------------
  reg sync_flags_r; // 1: synchronous flag timing
  reg little_end_r; // 1: least significant part first
  reg first_word_passthrough_r; // passthrough mode
  reg [1:0] ow_r; // output width code
  wire any_rst = ~mrst_s_n | ~prst_s_n;

  // straps are tracked while full reset is held; partial reset leaves them alone
  always @(posedge clk_sys) begin
    if (sys_rst) begin
      sync_flags_r <= 1'b0;
      little_end_r <= 1'b0;
      first_word_passthrough_r <= 1'b0;
      ow_r <= `OW_X36;
    end else if (~mrst_s_n) begin
      sync_flags_r <= fts_s; // [R15]
      little_end_r <= bos_s;
      first_word_passthrough_r <= first_word_passthrough_s;
      ow_r <= (ow_s == 2'h3) ? `OW_X36 : ow_s;
    end
  end

  // ----------------------------------------
  // storage and pointers
  // ----------------------------------------
  reg [35:0] mem [0:1023]; // data array
  reg [9:0] wr_ptr_r;
  reg [9:0] rd_ptr_r;
  reg [10:0] cnt_r; // stored words
  reg [1:0] lane_r; // narrow read position inside a word
  wire full = (cnt_r == `DEPTH);
  wire empty = (cnt_r == 11'h000);
  wire wr_req = wr_rise & ~wr_en_s_n;
  wire rd_req = rd_rise & ~rd_en_s_n & ~rd_sel_s_n;
  wire wr_go = wr_req & ~full;
  wire rd_go = rd_req & ~empty; // [R10]
  // last lane of a word: x18 takes two reads, x9 four [R16]
  wire [1:0] last_lane = (ow_r == `OW_X9) ? 2'h3 : ((ow_r == `OW_X18) ? 2'h1 : 2'h0);
  wire pop = rd_go & (lane_r == last_lane);
  wire [10:0] cnt_nxt = cnt_r + {10'h000, wr_go} - {10'h000, pop};

  // array write only; no reset needed for contents
  always @(posedge clk_sys) begin
    if (wr_go) begin
      mem[wr_ptr_r] <= din_s;
    end
  end

  // pointer and count bookkeeping
  always @(posedge clk_sys) begin
    if (sys_rst || any_rst) begin
      wr_ptr_r <= 10'h000; // [R17]
      rd_ptr_r <= 10'h000;
      cnt_r <= 11'h000;
      lane_r <= 2'h0;
    end else begin
      if (wr_go) begin
        wr_ptr_r <= wr_ptr_r + 10'h001;
      end
      if (rd_go) begin
        lane_r <= pop ? 2'h0 : lane_r + 2'h1; // [R16]
      end
      if (pop) begin
        rd_ptr_r <= rd_ptr_r + 10'h001;
      end
      cnt_r <= cnt_nxt;
    end
  end

  // ----------------------------------------
  // bus matching
  // ----------------------------------------
  wire [35:0] head = mem[rd_ptr_r]; // word at the read pointer
  // lanes counted from the least significant end; big endian starts from the top [R14]
  wire [1:0] part = little_end_r ? lane_r : (last_lane - lane_r);
  reg [35:0] out_nxt;

  // select the part of the word shown on the low output bits [R12] [R13]
  always @* begin
    out_nxt = 36'h000000000;
    case (ow_r)
      `OW_X18: begin
        out_nxt[17:0] = part[0] ? head[35:18] : head[17:0];
      end
      `OW_X9: begin
        case (part)
          2'h0: out_nxt[8:0] = head[8:0];
          2'h1: out_nxt[8:0] = head[17:9];
          2'h2: out_nxt[8:0] = head[26:18];
          default: out_nxt[8:0] = head[35:27];
        endcase
      end
      default: begin
        out_nxt = head;
      end
    endcase
  end

  // ----------------------------------------
  // read outputs and echoes
  // ----------------------------------------
  // data held until the next real read; echo clock is one sample behind the read clock
  always @(posedge clk_sys) begin
    if (sys_rst) begin
      out_bus <= 36'h000000000;
      echoed_rd_clk <= 1'b0;
      echoed_rd_strobe_n <= 1'b1;
    end else begin
      echoed_rd_clk <= rd_clk_s; // [R9]
      if (rd_rise) begin
        echoed_rd_strobe_n <= ~rd_go; // [R10]
      end
      if (rd_go) begin
        out_bus <= out_nxt; // [R12]
      end
    end
  end

  // ----------------------------------------
  // almost-empty offset
  // ----------------------------------------
  reg [9:0] ae_off_r; // empty offset n
  wire apb_wr = psel & penable & pready & pwrite;

  // serial load wins over a bus write in the same cycle; full reset restores the default
  always @(posedge clk_sys) begin
    if (sys_rst || ~mrst_s_n) begin
      ae_off_r <= `AE_OFFSET_RST;
    end else if (sclk_rise && ~sen_s_n) begin
      ae_off_r <= {ae_off_r[8:0], ser_s}; // [R11]
    end else if (apb_wr && paddr == `ADDR_AE_OFFSET) begin
      ae_off_r <= pwdata[9:0];
    end
  end

  // ----------------------------------------
  // almost-empty and half-full flags
  // ----------------------------------------
  wire [10:0] ae_thr = first_word_passthrough_r ? ({1'b0, ae_off_r} + 11'h001) : {1'b0, ae_off_r}; // [R1] [R2]
  wire ae_cond = (cnt_nxt <= ae_thr);
  // passthrough counts the output register word, so the threshold moves up one [R7] [R8]
  wire [10:0] hf_thr = first_word_passthrough_r ? (`HALF_DEPTH + 11'h001) : `HALF_DEPTH;
  wire hf_over = (cnt_nxt > hf_thr);

  // flag update by mode; both resets put flags at empty values
  always @(posedge clk_sys) begin
    if (sys_rst || any_rst) begin
      almost_empty_n <= 1'b0; // [R17]
      half_full_n <= 1'b1;
    end else begin
      if (sync_flags_r) begin
        if (rd_rise) begin
          almost_empty_n <= ~ae_cond; // [R4]
        end
      end else begin
        if (rd_rise && ae_cond) begin
          almost_empty_n <= 1'b0; // [R3]
        end else if (wr_rise && !ae_cond) begin
          almost_empty_n <= 1'b1; // [R3]
        end
      end
      if (wr_rise && hf_over) begin
        half_full_n <= 1'b0; // [R5]
      end else if (rd_rise && !hf_over) begin
        half_full_n <= 1'b1; // [R6]
      end
    end
  end

  // ----------------------------------------
  // interrupt status and mask
  // ----------------------------------------
  reg [`IRQ_W-1:0] irq_stat_r; // sticky events
  reg [`IRQ_W-1:0] irq_mask_r; // 1 enables the event
  reg ae_p_r, hf_p_r; // previous flag values for fall detection
  wire [`IRQ_W-1:0] irq_ev = {rd_req & empty, wr_req & full,
                              hf_p_r & ~half_full_n, ae_p_r & ~almost_empty_n};
  wire [`IRQ_W-1:0] irq_clr = (apb_wr && paddr == `ADDR_IRQ_STATUS) ? pwdata[`IRQ_W-1:0] : {`IRQ_W{1'b0}};

  // a new event beats a write-one-to-clear in the same cycle
  always @(posedge clk_sys) begin
    if (sys_rst) begin
      irq_stat_r <= {`IRQ_W{1'b0}};
      irq_mask_r <= {`IRQ_W{1'b0}};
      ae_p_r <= 1'b0;
      hf_p_r <= 1'b1;
      irq <= 1'b0;
    end else begin
      ae_p_r <= almost_empty_n;
      hf_p_r <= half_full_n;
      irq_stat_r <= (irq_stat_r & ~irq_clr) | irq_ev;
      if (apb_wr && paddr == `ADDR_IRQ_MASK) begin
        irq_mask_r <= pwdata[`IRQ_W-1:0];
      end
      irq <= |(irq_stat_r & irq_mask_r);
    end
  end

  // ----------------------------------------
  // apb slave
  // ----------------------------------------
  reg [31:0] rd_nxt;
  reg map_hit;

  // read mux and address decode
  always @* begin
    rd_nxt = 32'h00000000;
    map_hit = 1'b1;
    case (paddr)
      `ADDR_AE_OFFSET: rd_nxt = {22'h000000, ae_off_r};
      `ADDR_STATUS: rd_nxt = {14'h0000, lane_r, almost_empty_n, half_full_n, empty, full, 1'b0, cnt_r};
      `ADDR_IRQ_STATUS: rd_nxt = {28'h0000000, irq_stat_r};
      `ADDR_IRQ_MASK: rd_nxt = {28'h0000000, irq_mask_r};
      `ADDR_CONFIG: rd_nxt = {27'h0000000, ow_r, first_word_passthrough_r, little_end_r, sync_flags_r};
      default: map_hit = 1'b0;
    endcase
  end

  // answer prepared in the setup cycle so the access phase completes at once
  always @(posedge clk_sys) begin
    if (sys_rst) begin
      pready <= 1'b0;
      prdata <= 32'h00000000;
      pslverr <= 1'b0;
    end else if (psel && !penable) begin
      pready <= 1'b1;
      prdata <= pwrite ? 32'h00000000 : rd_nxt;
      pslverr <= ~map_hit;
    end else begin
      pready <= 1'b0;
      pslverr <= 1'b0;
    end
  end

endmodule // fifo_flags

/* bench/link_agent.sv */
// partner: write, read and serial agents on their own slow clocks
// assumes the block samples these pins with its 40 MHz clock
`timescale 1ns/1ps
module link_agent (
  // write side
  output logic wr_clk,
  output logic wr_en_n,
  output logic [35:0] din,
  // read side
  output logic rd_clk,
  output logic rd_en_n,
  output logic rd_select_n,
  // serial offset load
  output logic sclk,
  output logic serial_in,
  output logic serial_prog_en_n
);
  // clocks stand low between frames; released data shows the inverse
  initial begin
    {wr_clk, rd_clk, sclk} = 3'h0;
    {wr_en_n, rd_en_n, rd_select_n, serial_prog_en_n} = 4'hf;
    din = 36'h0;
    serial_in = 1'b0;
  end
  // one write, 200 ns period, 7 ns off the system clock phase
  task automatic push(input logic [35:0] w);
    #7 wr_en_n = 1'b0;
    din = w;
    #100 wr_clk = 1'b1;
    #100 wr_clk = 1'b0;
    wr_en_n = 1'b1;
    din = ~w;
  endtask
  // one read cycle; en_n is {read enable, read select}
  task automatic pull(input logic [1:0] en_n);
    #7 {rd_en_n, rd_select_n} = en_n;
    #100 rd_clk = 1'b1;
    #100 rd_clk = 1'b0;
    {rd_en_n, rd_select_n} = 2'h3;
  endtask
  // offset shifted in msb first while the enable is held low
  // data moves on the falling clock, 7 ns off the system clock edges, 200 ns period
  task automatic load(input logic [9:0] v);
    #7 serial_prog_en_n = 1'b0;
    for (int i = 9; i >= 0; i--) begin
      serial_in = v[i];
      #100 sclk = 1'b1;
      #100 sclk = 1'b0;
    end
    #100 serial_prog_en_n = 1'b1;
    serial_in = ~v[0];
  endtask
endmodule // link_agent

/* bench/fifo_flags_sva.sv */
// checker for fifo_flags: flag, echo and apb timing at the top ports
// assumes clk_sys samples every link pin, as the block itself does
`timescale 1ns/1ps
`include "fifo_flags_defines.vh"
module fifo_flags_sva (
  // clock and reset
  input wire clk_sys,
  input wire sys_rst,
  // apb answer
  input wire psel,
  input wire penable,
  input wire pready,
  input wire pslverr,
  // link pins and straps
  input wire wr_clk,
  input wire rd_clk,
  input wire full_reset_n,
  input wire partial_reset_n,
  input wire flag_timing_sel,
  input wire [1:0] out_width_sel,
  // read side and flags
  input wire [35:0] out_bus,
  input wire echoed_rd_clk,
  input wire echoed_rd_strobe_n,
  input wire almost_empty_n,
  input wire half_full_n
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  // ------
  // cycles since a pin rose or a reset pin was low, saturating
  // ------
  logic [3:0] wr_age, rd_age, rst_age;
  always @(posedge clk_sys) begin
    if (sys_rst) begin
      wr_age <= 4'hf;
      rd_age <= 4'hf;
      rst_age <= 4'h0;
    end else begin
      wr_age <= $rose(wr_clk) ? 4'h0 : wr_age + {3'h0, wr_age != 4'hf};
      rd_age <= $rose(rd_clk) ? 4'h0 : rd_age + {3'h0, rd_age != 4'hf};
      rst_age <= !(full_reset_n && partial_reset_n) ? 4'h0 : rst_age + {3'h0, rst_age != 4'hf};
    end
  end
  sequence apb_setup;
    psel && !penable;
  endsequence
  // pin sync plus one register gives about five cycles
  sequence rd_recent;
    rd_age <= 4'h8;
  endsequence
  pready_pulse_a: assert property (apb_setup |=> pready ##1 !pready)
    else $error("apb answer not a one-cycle pulse");
  err_ready_a: assert property (pslverr |-> pready)
    else $error("slave error without ready");
  reset_flags_a: assert property (disable iff (1'b0) sys_rst |=> !almost_empty_n && half_full_n)
    else $error("flags wrong after system reset");
  pin_reset_a: assert property ((!full_reset_n || !partial_reset_n) [*8] |-> !almost_empty_n && half_full_n)
    else $error("flags wrong in pin reset");
  hf_fall_a: assert property ($fell(half_full_n) |-> wr_age <= 4'h8)
    else $error("half full fell without write edge");
  hf_rise_a: assert property ($rose(half_full_n) |-> rd_age <= 4'h8 || rst_age <= 4'h8)
    else $error("half full rose without read edge");
  ae_fall_a: assert property ($fell(almost_empty_n) |-> rd_age <= 4'h8 || rst_age <= 4'h8)
    else $error("almost empty fell without read edge");
  ae_async_a: assert property (!flag_timing_sel && $rose(almost_empty_n) |-> wr_age <= 4'h8)
    else $error("async almost empty rose without write edge");
  ae_sync_a: assert property (flag_timing_sel && $rose(almost_empty_n) |-> rd_recent)
    else $error("sync almost empty moved off a read edge");
  echo_clk_a: assert property ($rose(rd_clk) |-> ##[2:8] $rose(echoed_rd_clk))
    else $error("echoed clock missed a read clock edge");
  strobe_cause_a: assert property ($fell(echoed_rd_strobe_n) |-> rd_recent)
    else $error("strobe fell without read edge");
  narrow_out_a: assert property ($changed(out_bus) |-> (out_width_sel != `OW_X9 || out_bus[35:9] == 27'h0)
    && (out_width_sel != `OW_X18 || out_bus[35:18] == 18'h0))
    else $error("narrow output drove upper bits");
endmodule // fifo_flags_sva
bind fifo_flags fifo_flags_sva sva (.clk_sys(clk_sys), .sys_rst(sys_rst), .psel(psel), .penable(penable),
  .pready(pready), .pslverr(pslverr), .wr_clk(wr_clk), .rd_clk(rd_clk), .full_reset_n(full_reset_n),
  .partial_reset_n(partial_reset_n), .flag_timing_sel(flag_timing_sel), .out_width_sel(out_width_sel),
  .out_bus(out_bus), .echoed_rd_clk(echoed_rd_clk), .echoed_rd_strobe_n(echoed_rd_strobe_n),
  .almost_empty_n(almost_empty_n), .half_full_n(half_full_n));

/* bench/fifo_flags_tb.sv */
// bench for fifo_flags: apb host, link agent and two queue monitors
// assumes link_agent drives the write, read and serial pins
`timescale 1ns/1ps
`include "fifo_flags_defines.vh"
module fifo_flags_tb;
  logic clk_sys, sys_rst, psel, penable, pwrite;
  logic [7:0] paddr;
  logic [31:0] pwdata;
  logic full_reset_n, partial_reset_n, flag_timing_sel, byte_order_sel, first_word_passthrough;
  logic [1:0] out_width_sel;
  wire [31:0] prdata;
  wire pready, pslverr, irq, wr_clk, wr_en_n, rd_clk, rd_en_n, rd_select_n, sclk, serial_in, serial_prog_en_n;
  wire echoed_rd_clk, echoed_rd_strobe_n, almost_empty_n, half_full_n;
  wire [35:0] din, out_bus;
  logic [35:0] d, wq[$], q_rd[$];
  logic [32:0] q_apb[$];
  int n_fail, checks;
  fifo_flags dut (.clk_sys(clk_sys), .sys_rst(sys_rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq),
    .wr_clk(wr_clk), .wr_en_n(wr_en_n), .din(din), .rd_clk(rd_clk), .rd_en_n(rd_en_n),
    .rd_select_n(rd_select_n), .out_bus(out_bus), .echoed_rd_clk(echoed_rd_clk),
    .echoed_rd_strobe_n(echoed_rd_strobe_n), .sclk(sclk), .serial_in(serial_in),
    .serial_prog_en_n(serial_prog_en_n), .full_reset_n(full_reset_n), .partial_reset_n(partial_reset_n),
    .flag_timing_sel(flag_timing_sel), .byte_order_sel(byte_order_sel),
    .first_word_passthrough(first_word_passthrough), .out_width_sel(out_width_sel),
    .almost_empty_n(almost_empty_n), .half_full_n(half_full_n));
  link_agent agent (.wr_clk(wr_clk), .wr_en_n(wr_en_n), .din(din), .rd_clk(rd_clk), .rd_en_n(rd_en_n),
    .rd_select_n(rd_select_n), .sclk(sclk), .serial_in(serial_in), .serial_prog_en_n(serial_prog_en_n));
  initial begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end
  task automatic check(input logic [35:0] seen, input logic [35:0] exp);
    checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic tally_and_finish;
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  // apb transfer; a read notes {pslverr, prdata} for the monitor
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] v, input logic [32:0] exp);
    @(posedge clk_sys);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= v;
    if (!w) q_apb.push_back(exp);
    @(posedge clk_sys);
    penable <= 1'b1;
    // no local limit: only the watchdog ends a wait for the answer
    do begin
      @(posedge clk_sys);
    end while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // pin reset held well past the synchroniser; stored words are gone
  task automatic rst(input logic full);
    @(posedge clk_sys);
    if (full) full_reset_n <= 1'b0;
    else partial_reset_n <= 1'b0;
    repeat (10) @(posedge clk_sys);
    full_reset_n <= 1'b1;
    partial_reset_n <= 1'b1;
    repeat (8) @(posedge clk_sys);
    wq.delete();
  endtask
  // expected narrow part p of word w: c=0 x18 little, c=1 x9 big
  function automatic logic [35:0] part(input logic [35:0] w, input int c, input int p);
    int k;
    k = c ? 3 - p : p;
    return c ? 36'(w[9 * k +: 9]) : 36'(w[18 * k +: 18]);
  endfunction
  always @(posedge clk_sys)
    if (psel && penable && pready && !pwrite) check({3'h0, pslverr, prdata}, {3'h0, q_apb.pop_front()});
  // a real read shows a low strobe; an empty queue then means a mismatch
  always @(posedge rd_clk) begin
    repeat (7) @(posedge clk_sys);
    if (echoed_rd_strobe_n === 1'b0) check(out_bus, q_rd.size() ? q_rd.pop_front() : 36'hx);
  end
  initial begin
    {sys_rst, full_reset_n, partial_reset_n} = 3'h7;
    {psel, penable, pwrite, paddr, pwdata} = 43'h0;
    {flag_timing_sel, byte_order_sel, first_word_passthrough, out_width_sel} = 5'h0;
    n_fail = 0;
    checks = 0;
    void'($urandom(89));
    repeat (3) @(posedge clk_sys);
    sys_rst <= 1'b0;
    apb(1'b0, `ADDR_STATUS, 32'h0, 33'h6000);
    apb(1'b0, 8'h40, 32'h0, 33'h100000000);
    for (int i = 1; i <= 513; i++) begin
      d = 36'({$urandom(), $urandom()});
      agent.push(d);
      wq.push_back(d);
      repeat (4) @(posedge clk_sys);
      check(almost_empty_n, i > 127);
      check(half_full_n, i < 513);
    end
    q_rd.push_back(wq.pop_front());
    agent.pull(2'h0);
    repeat (4) @(posedge clk_sys);
    check(half_full_n, 1'b1);
    agent.pull(2'h1);
    rst(1'b0);
    apb(1'b0, `ADDR_STATUS, 32'h0, 33'h6000);
    apb(1'b1, `ADDR_IRQ_STATUS, 32'hf, 33'h0);
    agent.pull(2'h0);
    apb(1'b0, `ADDR_IRQ_STATUS, 32'h0, 33'h8);
    for (int m = 0; m < 3; m++) begin
      apb(1'b1, `ADDR_IRQ_MASK, m == 1 ? 32'h0 : 32'h8, 33'h0);
      repeat (2) @(posedge clk_sys);
      check(irq, m != 1);
    end
    apb(1'b1, `ADDR_IRQ_STATUS, 32'h8, 33'h0);
    repeat (2) @(posedge clk_sys);
    check(irq, 1'b0);
    for (int c = 0; c < 2; c++) begin
      flag_timing_sel <= !c;
      byte_order_sel <= !c;
      first_word_passthrough <= !c;
      out_width_sel <= c ? `OW_X9 : `OW_X18;
      rst(1'b1);
      apb(1'b0, `ADDR_CONFIG, 32'h0, c ? 33'h10 : 33'hf);
      agent.load(10'h3);
      apb(1'b0, `ADDR_AE_OFFSET, 32'h0, 33'h3);
      for (int i = 0; i < 5; i++) begin
        d = 36'({$urandom(), $urandom()});
        agent.push(d);
        wq.push_back(d);
      end
      repeat (4) @(posedge clk_sys);
      check(almost_empty_n, c[0]);
      for (int w = 0; w < 2; w++) begin
        d = wq.pop_front();
        for (int p = 0; p < (c ? 4 : 2); p++) begin
          q_rd.push_back(part(d, c, p));
          agent.pull(2'h0);
          repeat (4) @(posedge clk_sys);
        end
        check(almost_empty_n, c == 1 && w == 0);
      end
    end
    repeat (10) @(posedge clk_sys);
    // every noted read part must have shown a low strobe and been taken
    check(36'(q_rd.size()), 36'h0);
    tally_and_finish();
  end
  initial begin
    #1000000;
    n_fail++;
    tally_and_finish();
  end
endmodule // fifo_flags_tb
